//--- logic/hbp_cfg.svh
// Constants of the host bus port: transfer sizes, map offsets, reset values.
// Assumes inclusion by hbp_pkg and the two port ends only.
// Notes on behaviour
// - Register access only while chip select low
// - Data strobe latches writes, enables read data
// - Slave drives transfer acknowledge to end access
// - While requesting, acknowledge high means bus free
// - Master cycle ends on memory transfer acknowledge
// - Long and three-byte sizes acknowledged, not performed
// - Pass acknowledge down chain when nothing pending at the acknowledged level
// - Three open-drain requests: modem, transmit, receive
// - Bus request low only while waiting for mastership
// - Grant out only when granted and idle
// - Grant acknowledge driven while owning, sampled otherwise
// - Bus error ends cycle, frees bus, interrupts
// - Load strobe shows address 31:8 for latching
// - Master muxes address then data on lines
// - Address enable on during master cycles
// - Data enable when master or selected strobe
// - Data direction low when data flows outward
// - Bus clock is clock halved, low in reset
// - Reset state then one initialisation pulse
// - Test input floats bus clock, grant, acknowledge
// - Strap picks byte lane and string order
// - Strap picks one of two register maps
`ifndef HBP_CFG_SVH
`define HBP_CFG_SVH
`define HBP_SIZ_LONG 2'h0
`define HBP_SIZ_BYTE 2'h1
`define HBP_SIZ_WORD 2'h2
`define HBP_SIZ_TRI 2'h3
`define HBP_MAP_XOR_BYTE 8'h03
`define HBP_MAP_XOR_WORD 8'h02
`define HBP_HALF_RATE_BUS_CLOCK_RST 1'h0
`define HBP_LVL_NONE 2'h0
`define HBP_MEM_AW 8
`define HBP_MEM_WAIT 2
`endif

//--- logic/hbp_pkg.sv
// Types shared by both ends of the host bus port.
// Assumes hbp_cfg.svh is on the include path.
package hbp_pkg;
  `include "hbp_cfg.svh"

  typedef enum logic [2:0] {
    DM_IDLE = 3'b000,
    DM_REQ = 3'b001,
    DM_LOAD = 3'b010,
    DM_ADDR = 3'b011,
    DM_DATA = 3'b100,
    DM_DONE = 3'b101
  } hbp_dma_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_STRB = 2'b01,
    HS_WAIT = 2'b10,
    HS_REL = 2'b11
  } hbp_host_e;

  typedef struct packed {
    hbp_dma_e st;
    logic clkdiv;
    logic init;
    logic [31:0] addr;
    logic wr;
    logic byte_x;
    logic [15:0] wdata;
    logic [15:0] ad;
    logic ad_en;
    logic [1:0] sph;
    logic transfer_ack_n;
    logic reg_rd;
    logic reg_wr;
    logic [7:0] reg_addr;
    logic [1:0] reg_size;
    logic [15:0] reg_wdata;
    logic iack_hit;
    logic iack_pass;
    logic iack_take;
    logic [1:0] iack_lvl;
    logic done;
    logic err_pulse;
    logic err;
    logic [15:0] rdata;
  } hbp_dev_s;

  typedef struct packed {
    hbp_host_e st;
    logic wr;
    logic iack;
    logic [7:0] addr;
    logic [1:0] siz;
    logic [15:0] wdata;
    logic rsp_valid;
    logic rsp_chain;
    logic [15:0] rsp_data;
    logic grant;
    logic [23:0] mem_hi;
    logic [15:0] mem_lo;
    logic [3:0] mem_cnt;
    logic mem_ack;
    logic mem_bus_error_n;
    logic mem_ad_en;
    logic [15:0] mem_ad;
  } hbp_host_s;
endpackage : hbp_pkg

//--- logic/hbp_bus_if.sv
// Pin-level bus between the port device and the host side.
// Resolves tristate and open-drain pins from drive enables; idle lines pull high.
`timescale 1ns/1ps
interface hbp_bus_if;
  logic cs_n, iack_in_n, bus_grant_in_n_n, bus_error_n_n;
  logic iack_out_n, iack_out_oe_n, bus_grant_out_n_n, bus_grant_out_n_oe_n, half_rate_bus_clock, half_rate_bus_clock_oe_n;
  logic address_load_n_n, aen_n, data_buffer_enable_n_n, data_buffer_direction_n_n;
  logic dev_ctl_oe_n, dev_as_n, dev_ds_n, dev_rw_n;
  logic [1:0] dev_siz;
  logic dev_a_oe_n, dev_ad_oe_n;
  logic [7:0] dev_a;
  logic [15:0] dev_ad;
  logic host_ctl_oe_n, host_as_n, host_ds_n, host_rw_n;
  logic [1:0] host_siz;
  logic host_a_oe_n, host_ad_oe_n;
  logic [7:0] host_a;
  logic [15:0] host_ad;
  logic dev_transfer_ack_n_o, dev_transfer_ack_n_oe_n, host_transfer_ack_n_o, host_transfer_ack_n_oe_n;
  logic dev_br_o, dev_br_oe_n, dev_bus_grant_ack_n_o, dev_bus_grant_ack_n_oe_n;
  logic [2:0] dev_irq_o, dev_irq_oe_n;
  logic as_n, ds_n, rw_n;
  logic [1:0] siz;
  logic [7:0] a;
  logic [15:0] ad;
  logic transfer_ack_n_n, br_n, bus_grant_ack_n_n;
  logic [2:0] irq_n;
  logic iack_out_w, bus_grant_out_n_w, half_rate_bus_clock_w;

  assign as_n = !dev_ctl_oe_n ? dev_as_n : (!host_ctl_oe_n ? host_as_n : 1'b1);
  assign ds_n = !dev_ctl_oe_n ? dev_ds_n : (!host_ctl_oe_n ? host_ds_n : 1'b1);
  assign rw_n = !dev_ctl_oe_n ? dev_rw_n : (!host_ctl_oe_n ? host_rw_n : 1'b1);
  assign siz = !dev_ctl_oe_n ? dev_siz : (!host_ctl_oe_n ? host_siz : 2'h3);
  assign a = !dev_a_oe_n ? dev_a : (!host_a_oe_n ? host_a : 8'hff);
  assign ad = !dev_ad_oe_n ? dev_ad : (!host_ad_oe_n ? host_ad : 16'hffff);
  assign transfer_ack_n_n = (dev_transfer_ack_n_oe_n | dev_transfer_ack_n_o) & (host_transfer_ack_n_oe_n | host_transfer_ack_n_o);
  assign br_n = dev_br_oe_n | dev_br_o;
  assign bus_grant_ack_n_n = dev_bus_grant_ack_n_oe_n | dev_bus_grant_ack_n_o;
  assign irq_n = dev_irq_oe_n | dev_irq_o;
  assign iack_out_w = iack_out_oe_n | iack_out_n;
  assign bus_grant_out_n_w = bus_grant_out_n_oe_n | bus_grant_out_n_n;
  assign half_rate_bus_clock_w = half_rate_bus_clock_oe_n | half_rate_bus_clock;

  modport dev (
    input cs_n, iack_in_n, bus_grant_in_n_n, bus_error_n_n, as_n, ds_n, rw_n, siz, a, ad, transfer_ack_n_n, bus_grant_ack_n_n,
    output iack_out_n, iack_out_oe_n, bus_grant_out_n_n, bus_grant_out_n_oe_n, half_rate_bus_clock, half_rate_bus_clock_oe_n,
    output address_load_n_n, aen_n, data_buffer_enable_n_n, data_buffer_direction_n_n, dev_ctl_oe_n, dev_as_n, dev_ds_n, dev_rw_n,
    output dev_siz, dev_a_oe_n, dev_ad_oe_n, dev_a, dev_ad, dev_transfer_ack_n_o, dev_transfer_ack_n_oe_n,
    output dev_br_o, dev_br_oe_n, dev_bus_grant_ack_n_o, dev_bus_grant_ack_n_oe_n, dev_irq_o, dev_irq_oe_n
  );
  modport host (
    output cs_n, iack_in_n, bus_grant_in_n_n, bus_error_n_n, host_ctl_oe_n, host_as_n, host_ds_n,
    output host_rw_n, host_siz, host_a_oe_n, host_ad_oe_n, host_a, host_ad,
    output host_transfer_ack_n_o, host_transfer_ack_n_oe_n,
    input as_n, ds_n, rw_n, siz, a, ad, transfer_ack_n_n, br_n, bus_grant_ack_n_n, irq_n,
    input iack_out_w, bus_grant_out_n_w, half_rate_bus_clock_w, address_load_n_n, aen_n
  );
endinterface : hbp_bus_if

//--- logic/hbp_dev.sv
// Device end of the host bus port: register slave, interrupt acknowledge,
// daisy-chained bus arbitration and single-word DMA master cycles.
// Assumes the register core answers reg_rdata_i in the same cycle as reg_rd_o.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module hbp_dev
  import hbp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  hbp_bus_if.dev bus,
  input wire logic byte_order_strap_i,
  input wire logic test_i,
  output logic init_o,
  output logic [7:0] reg_addr_o,
  output logic [1:0] reg_size_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [15:0] reg_wdata_o,
  input wire logic [15:0] reg_rdata_i,
  input wire logic [2:0] int_req_i,
  input wire logic [7:0] int_vector_i,
  output logic iack_take_o,
  output logic [1:0] iack_level_o,
  input wire logic dma_valid_i,
  output logic dma_ready_o,
  input wire logic dma_write_i,
  input wire logic dma_byte_i,
  input wire logic [31:0] dma_addr_i,
  input wire logic [15:0] dma_wdata_i,
  output logic dma_done_o,
  output logic [15:0] dma_rdata_o,
  output logic bus_error_o,
  input wire logic bus_error_clr_i
);
  hbp_dev_s s_ff;
  hbp_dev_s nxt_s;
  logic master;
  logic sel;

  // True when the byte sits on the upper lane
  function automatic logic lane_hi(input logic strap, input logic a0);
    lane_hi = strap ? a0 : !a0;
  endfunction : lane_hi

  // Word in string order: first byte in [7:0]
  function automatic logic [15:0] str_order(input logic strap, input logic [15:0] w);
    str_order = strap ? w : {w[7:0], w[15:8]};
  endfunction : str_order

  // Offsets presented to the core always follow the low-byte-first map
  function automatic logic [7:0] map_addr(input logic strap, input logic [7:0] a,
                                          input logic [1:0] sz);
    if (strap) begin
      map_addr = a;
    end else if (sz == `HBP_SIZ_WORD) begin
      map_addr = a ^ `HBP_MAP_XOR_WORD;
    end else begin
      map_addr = a ^ `HBP_MAP_XOR_BYTE;
    end
  endfunction : map_addr

  assign master = (s_ff.st == DM_LOAD) || (s_ff.st == DM_ADDR) || (s_ff.st == DM_DATA);
  assign sel = !bus.cs_n && !bus.ds_n && !master;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.clkdiv = !s_ff.clkdiv;
    // Held through reset and for the first cycle after it, while the divider is first high
    nxt_s.init = s_ff.init && !s_ff.clkdiv;
    nxt_s.reg_rd = 1'b0;
    nxt_s.reg_wr = 1'b0;
    nxt_s.iack_take = 1'b0;
    nxt_s.done = 1'b0;
    nxt_s.err_pulse = 1'b0;
    if (bus_error_clr_i) begin
      nxt_s.err = 1'b0;
    end

    // Slave side: phase 1 latches address, phase 2 answers
    // Acknowledge drops with the strobe, or the host would wait forever in an
    // acknowledge cycle; a passed acknowledge lasts until acknowledge-in goes high
    if (master || bus.ds_n) begin
      nxt_s.sph = 2'h0;
      nxt_s.transfer_ack_n = 1'b0;
      nxt_s.iack_hit = 1'b0;
      if (master || bus.iack_in_n) begin
        nxt_s.iack_pass = 1'b0;
      end
      if (!master) begin
        nxt_s.ad_en = 1'b0;
      end
    end else if (!bus.ds_n && !bus.iack_in_n && s_ff.sph == 2'h0) begin
      nxt_s.sph = 2'h1;
      nxt_s.iack_lvl = bus.a[1:0];
      if (bus.a[1:0] != `HBP_LVL_NONE && int_req_i[bus.a[1:0] - 2'h1]) begin
        nxt_s.iack_hit = 1'b1;
        nxt_s.iack_take = 1'b1;
      end else begin
        nxt_s.iack_pass = 1'b1;
      end
    end else if (s_ff.sph == 2'h1 && s_ff.iack_hit) begin
      nxt_s.sph = 2'h2;
      nxt_s.ad = {8'h00, int_vector_i};
      nxt_s.ad_en = 1'b1;
      nxt_s.transfer_ack_n = 1'b1;
    end else if (sel && s_ff.sph == 2'h0) begin
      nxt_s.sph = 2'h1;
      nxt_s.reg_size = bus.siz;
      nxt_s.reg_addr = map_addr(byte_order_strap_i, bus.a, bus.siz);
      if (bus.siz == `HBP_SIZ_BYTE || bus.siz == `HBP_SIZ_WORD) begin
        nxt_s.reg_rd = bus.rw_n;
        nxt_s.reg_wr = !bus.rw_n;
        if (bus.siz == `HBP_SIZ_BYTE) begin
          nxt_s.reg_wdata = {8'h00, lane_hi(byte_order_strap_i, bus.a[0]) ?
                             bus.ad[15:8] : bus.ad[7:0]};
        end else begin
          nxt_s.reg_wdata = bus.ad;
        end
      end
    end else if (sel && s_ff.sph == 2'h1) begin
      nxt_s.sph = 2'h2;
      nxt_s.transfer_ack_n = 1'b1;
      if (bus.rw_n && (s_ff.reg_size == `HBP_SIZ_BYTE || s_ff.reg_size == `HBP_SIZ_WORD)) begin
        nxt_s.ad_en = 1'b1;
        nxt_s.ad = (s_ff.reg_size == `HBP_SIZ_BYTE) ?
                   {reg_rdata_i[7:0], reg_rdata_i[7:0]} : reg_rdata_i;
      end
    end

    // DMA master
    unique case (s_ff.st)
      DM_IDLE: begin
        if (dma_valid_i && s_ff.sph == 2'h0 && bus.cs_n) begin
          nxt_s.st = DM_REQ;
          nxt_s.addr = dma_addr_i;
          nxt_s.wr = dma_write_i;
          nxt_s.byte_x = dma_byte_i;
          nxt_s.wdata = dma_wdata_i;
        end
      end
      DM_REQ: begin
        // Previous owner gone: no acknowledge, no other grant holder
        if (!bus.bus_grant_in_n_n && bus.transfer_ack_n_n && bus.bus_grant_ack_n_n && bus.cs_n) begin
          nxt_s.st = DM_LOAD;
          nxt_s.ad = s_ff.addr[31:16];
          nxt_s.ad_en = 1'b1;
        end
      end
      DM_LOAD: begin
        nxt_s.st = DM_ADDR;
        nxt_s.ad = s_ff.addr[15:0];
      end
      DM_ADDR: begin
        nxt_s.st = DM_DATA;
        nxt_s.ad_en = s_ff.wr;
        if (s_ff.byte_x) begin
          nxt_s.ad = {s_ff.wdata[7:0], s_ff.wdata[7:0]};
        end else begin
          nxt_s.ad = str_order(byte_order_strap_i, s_ff.wdata);
        end
      end
      DM_DATA: begin
        if (!bus.bus_error_n_n) begin
          nxt_s.st = DM_DONE;
          nxt_s.err_pulse = 1'b1;
          nxt_s.err = 1'b1;
          nxt_s.ad_en = 1'b0;
        end else if (!bus.transfer_ack_n_n) begin
          nxt_s.st = DM_DONE;
          nxt_s.done = 1'b1;
          nxt_s.ad_en = 1'b0;
          if (s_ff.byte_x) begin
            nxt_s.rdata = {8'h00, lane_hi(byte_order_strap_i, s_ff.addr[0]) ?
                           bus.ad[15:8] : bus.ad[7:0]};
          end else begin
            nxt_s.rdata = str_order(byte_order_strap_i, bus.ad);
          end
        end
      end
      DM_DONE: begin
        nxt_s.st = DM_IDLE;
      end
      default: begin
        nxt_s.st = DM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
      s_ff.init <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign init_o = s_ff.init;
  assign reg_addr_o = s_ff.reg_addr;
  assign reg_size_o = s_ff.reg_size;
  assign reg_rd_o = s_ff.reg_rd;
  assign reg_wr_o = s_ff.reg_wr;
  assign reg_wdata_o = s_ff.reg_wdata;
  assign iack_take_o = s_ff.iack_take;
  assign iack_level_o = s_ff.iack_lvl;
  assign dma_ready_o = (s_ff.st == DM_IDLE) && (s_ff.sph == 2'h0) && bus.cs_n;
  assign dma_done_o = s_ff.done;
  assign dma_rdata_o = s_ff.rdata;
  assign bus_error_o = s_ff.err;

  // Bus clock halts low for the whole reset
  assign bus.half_rate_bus_clock = rst_i ? `HBP_HALF_RATE_BUS_CLOCK_RST : s_ff.clkdiv;
  assign bus.half_rate_bus_clock_oe_n = test_i;
  assign bus.bus_grant_out_n_oe_n = test_i;
  assign bus.iack_out_oe_n = test_i;
  assign bus.iack_out_n = !(s_ff.iack_pass && !bus.iack_in_n);
  // Pending request blocks the grant from travelling on
  assign bus.bus_grant_out_n_n = !(!bus.bus_grant_in_n_n && s_ff.st == DM_IDLE && !dma_valid_i);

  assign bus.dev_ctl_oe_n = !master;
  assign bus.dev_as_n = !(s_ff.st == DM_ADDR || s_ff.st == DM_DATA);
  assign bus.dev_ds_n = !(s_ff.st == DM_DATA);
  assign bus.dev_rw_n = !s_ff.wr;
  assign bus.dev_siz = s_ff.byte_x ? `HBP_SIZ_BYTE : `HBP_SIZ_WORD;
  assign bus.dev_a_oe_n = !master;
  assign bus.dev_a = (s_ff.st == DM_LOAD) ? s_ff.addr[15:8] : s_ff.addr[7:0];
  assign bus.dev_ad_oe_n = !s_ff.ad_en;
  assign bus.dev_ad = s_ff.ad;
  assign bus.address_load_n_n = !(s_ff.st == DM_LOAD);
  assign bus.aen_n = !master;
  assign bus.data_buffer_enable_n_n = !(master || (!bus.cs_n && !bus.ds_n));
  assign bus.data_buffer_direction_n_n = !((master && s_ff.wr) || (!bus.cs_n && bus.rw_n));

  assign bus.dev_transfer_ack_n_o = 1'b0;
  assign bus.dev_transfer_ack_n_oe_n = !s_ff.transfer_ack_n;
  assign bus.dev_br_o = 1'b0;
  assign bus.dev_br_oe_n = !(s_ff.st == DM_REQ);
  assign bus.dev_bus_grant_ack_n_o = 1'b0;
  assign bus.dev_bus_grant_ack_n_oe_n = !master;
  assign bus.dev_irq_o = 3'h0;
  // Bus error is reported on the modem line
  assign bus.dev_irq_oe_n = ~(int_req_i | {2'h0, s_ff.err});
endmodule : hbp_dev

//--- logic/hbp_host.sv
// Far end of the host bus port: processor cycles, grant arbiter and a
// small system memory that answers DMA cycles.
// Assumes the device end shares clk_i and rst_i.
`timescale 1ns/1ps
`include "hbp_cfg.svh"
module hbp_host
  import hbp_pkg::*;
#(
  parameter int MEM_AW = `HBP_MEM_AW,
  parameter int MEM_WAIT = `HBP_MEM_WAIT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  hbp_bus_if.host bus,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire logic cmd_iack_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [1:0] cmd_size_i,
  input wire logic [15:0] cmd_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_chain_o,
  output logic [15:0] rsp_data_o,
  input wire logic bus_error_n_inject_i,
  output logic [2:0] irq_o
);
  if (MEM_AW < 1 || MEM_AW > 15) begin : g_chk_aw
    $error("MEM_AW out of range");
  end
  if (MEM_WAIT < 0 || MEM_WAIT > 14) begin : g_chk_wait
    $error("MEM_WAIT out of range");
  end

  localparam logic [3:0] WAIT_N = 4'(MEM_WAIT);
  hbp_host_s s_ff;
  hbp_host_s nxt_s;
  logic [15:0] mem_ff [2**MEM_AW];
  logic mem_cyc;
  logic mem_we;
  logic [MEM_AW-1:0] idx;

  assign mem_cyc = !bus.bus_grant_ack_n_n && !bus.aen_n && !bus.ds_n;
  assign idx = s_ff.mem_lo[MEM_AW:1];
  assign mem_we = mem_cyc && !bus.rw_n && s_ff.mem_cnt == WAIT_N && !bus_error_n_inject_i;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rsp_valid = 1'b0;
    nxt_s.rsp_chain = 1'b0;
    // Arbiter: grant a request while idle, withdraw once ownership is taken
    if (!bus.br_n && s_ff.st == HS_IDLE) begin
      nxt_s.grant = 1'b1;
    end else if (!bus.bus_grant_ack_n_n || bus.br_n) begin
      nxt_s.grant = 1'b0;
    end
    unique case (s_ff.st)
      HS_IDLE: begin
        if (cmd_valid_i && cmd_ready_o) begin
          nxt_s.st = HS_STRB;
          nxt_s.wr = cmd_write_i;
          nxt_s.iack = cmd_iack_i;
          nxt_s.addr = cmd_addr_i;
          nxt_s.siz = cmd_size_i;
          nxt_s.wdata = cmd_wdata_i;
        end
      end
      HS_STRB: begin
        nxt_s.st = HS_WAIT;
      end
      HS_WAIT: begin
        if (!bus.transfer_ack_n_n) begin
          nxt_s.st = HS_REL;
          nxt_s.rsp_valid = 1'b1;
          nxt_s.rsp_data = bus.ad;
        end else if (s_ff.iack && !bus.iack_out_w) begin
          nxt_s.st = HS_REL;
          nxt_s.rsp_chain = 1'b1;
        end
      end
      HS_REL: begin
        if (bus.transfer_ack_n_n) begin
          nxt_s.st = HS_IDLE;
        end
      end
    endcase
    // Memory: latch upper then lower address, answer after MEM_WAIT cycles
    if (!bus.address_load_n_n) begin
      nxt_s.mem_hi = {bus.ad, bus.a};
    end
    if (!bus.as_n && bus.ds_n) begin
      nxt_s.mem_lo = bus.ad;
    end
    if (mem_cyc) begin
      if (s_ff.mem_cnt != WAIT_N) begin
        nxt_s.mem_cnt = s_ff.mem_cnt + 4'h1;
      end else begin
        nxt_s.mem_ack = !bus_error_n_inject_i;
        nxt_s.mem_bus_error_n = bus_error_n_inject_i;
        nxt_s.mem_ad_en = bus.rw_n && !bus_error_n_inject_i;
        nxt_s.mem_ad = mem_ff[idx];
      end
    end else begin
      nxt_s.mem_cnt = 4'h0;
      nxt_s.mem_ack = 1'b0;
      nxt_s.mem_bus_error_n = 1'b0;
      nxt_s.mem_ad_en = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
      if (mem_we) begin
        mem_ff[idx] <= bus.ad;
      end
    end
  end

  assign cmd_ready_o = (s_ff.st == HS_IDLE) && !s_ff.grant && bus.bus_grant_ack_n_n && bus.br_n;
  assign rsp_valid_o = s_ff.rsp_valid;
  assign rsp_chain_o = s_ff.rsp_chain;
  assign rsp_data_o = s_ff.rsp_data;
  assign irq_o = ~bus.irq_n;

  assign bus.cs_n = !(s_ff.st != HS_IDLE && !s_ff.iack);
  assign bus.iack_in_n = !(s_ff.st != HS_IDLE && s_ff.iack);
  assign bus.bus_grant_in_n_n = !s_ff.grant;
  assign bus.bus_error_n_n = !s_ff.mem_bus_error_n;
  assign bus.host_ctl_oe_n = (s_ff.st == HS_IDLE);
  assign bus.host_as_n = 1'b0;
  assign bus.host_ds_n = !(s_ff.st == HS_WAIT);
  assign bus.host_rw_n = !s_ff.wr;
  assign bus.host_siz = s_ff.siz;
  assign bus.host_a_oe_n = (s_ff.st == HS_IDLE);
  assign bus.host_a = s_ff.addr;
  assign bus.host_ad_oe_n = !((s_ff.st != HS_IDLE && s_ff.wr && !s_ff.iack) || s_ff.mem_ad_en);
  assign bus.host_ad = s_ff.mem_ad_en ? s_ff.mem_ad : s_ff.wdata;
  assign bus.host_transfer_ack_n_o = 1'b0;
  assign bus.host_transfer_ack_n_oe_n = !s_ff.mem_ack;
endmodule : hbp_host

//--- verification/hbp_monitor.sv
// Concurrent checks on the pins joining the device end and the host end.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module hbp_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic half_rate_bus_clock,
  input wire logic cs_n,
  input wire logic ds_n,
  input wire logic as_n,
  input wire logic rw_n,
  input wire logic transfer_ack_n_n,
  input wire logic br_n,
  input wire logic bus_grant_in_n_n,
  input wire logic bus_grant_out_n_n,
  input wire logic bus_grant_ack_n_n,
  input wire logic bus_error_n_n,
  input wire logic aen_n,
  input wire logic address_load_n_n,
  input wire logic data_buffer_enable_n_n,
  input wire logic data_buffer_direction_n_n,
  input wire logic iack_in_n,
  input wire logic iack_out_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  clk_half_a: assert property (!$past(rst_i) |-> half_rate_bus_clock != $past(half_rate_bus_clock))
    else $error("bus clock missed a toggle");
  ack_timing_a: assert property (!cs_n && $fell(ds_n) |-> ##2 !transfer_ack_n_n)
    else $error("register acknowledge late or early");
  ack_hold_a: assert property (!cs_n && !ds_n && !transfer_ack_n_n |=> !transfer_ack_n_n)
    else $error("acknowledge dropped under strobe");
  ack_release_a: assert property ($rose(ds_n) && bus_grant_ack_n_n && $past(bus_grant_ack_n_n) |=> transfer_ack_n_n)
    else $error("acknowledge held after strobe");
  sel_enable_a: assert property ($past(!cs_n && !ds_n) && !cs_n && !ds_n |-> !data_buffer_enable_n_n)
    else $error("data enable off during access");
  read_dir_a: assert property ($past(!cs_n && rw_n) && !cs_n && rw_n |-> !data_buffer_direction_n_n)
    else $error("direction wrong on host read");
  master_drive_a: assert property (!bus_grant_ack_n_n |-> !aen_n && !data_buffer_enable_n_n)
    else $error("enables off while owning bus");
  load_then_addr_a: assert property (!address_load_n_n |-> !bus_grant_ack_n_n ##1 (address_load_n_n && !as_n))
    else $error("address phase missing after load");
  mem_wait_a: assert property (!bus_grant_ack_n_n && !ds_n && transfer_ack_n_n && bus_error_n_n |=> !bus_grant_ack_n_n)
    else $error("bus freed before acknowledge");
  bus_error_n_free_a: assert property (!bus_grant_ack_n_n && !bus_error_n_n |-> ##[1:2] bus_grant_ack_n_n)
    else $error("bus kept after bus error");
  grant_pass_a: assert property (!bus_grant_out_n_n |-> br_n && (!bus_grant_in_n_n || !$past(bus_grant_in_n_n)))
    else $error("grant passed while requesting");
  iack_pass_a: assert property (!iack_out_n |-> !$past(iack_in_n))
    else $error("acknowledge out without acknowledge in");
endmodule : hbp_monitor

//--- verification/host_bus_and_dma_master_port_tb_top.sv
// Self-checking bench: host end and device end joined by the pin interface.
// Assumes the host end arbitrates the grant and models system memory.
`timescale 1ns/1ps
module host_bus_and_dma_master_port_tb_top;
  import hbp_pkg::*;
  logic clk_i = 0, rst_i = 1, strap = 1, test = 0;
  logic cv = 0, cw = 0, ci = 0, cr, rv, rc, ok, chn, pl = 0;
  logic [7:0] ca = 0, vec = 8'h77, wa, ra, ld_a, a_lo;
  logic [1:0] cs = 2, lvl, tl, rsz;
  logic [9:0] rdl;
  logic [15:0] cd = 0, rd, rsp, wd, rwd, ld_ad, ad_lo, drd, dwd = 0;
  logic [2:0] ireq = 0, irq;
  logic dv = 0, dw = 0, db = 0, dr, dn, be, bclr = 0, binj = 0, init, take, rrd, rwr;
  logic [31:0] da = 0;
  int err_total = 0, tests_run = 0, wcnt = 0, n, m;

  hbp_bus_if bus ();
  hbp_dev u_hbp_dev (.clk_i, .rst_i, .bus(bus.dev), .byte_order_strap_i(strap),
    .test_i(test), .init_o(init), .reg_addr_o(ra), .reg_size_o(rsz), .reg_rd_o(rrd),
    .reg_wr_o(rwr), .reg_wdata_o(rwd), .reg_rdata_i({8'h5a, ra}), .int_req_i(ireq),
    .int_vector_i(vec), .iack_take_o(take), .iack_level_o(lvl), .dma_valid_i(dv),
    .dma_ready_o(dr), .dma_write_i(dw), .dma_byte_i(db), .dma_addr_i(da),
    .dma_wdata_i(dwd), .dma_done_o(dn), .dma_rdata_o(drd), .bus_error_o(be),
    .bus_error_clr_i(bclr));
  hbp_host #(.MEM_WAIT(1)) u_hbp_host (.clk_i, .rst_i, .bus(bus.host), .cmd_valid_i(cv),
    .cmd_ready_o(cr), .cmd_write_i(cw), .cmd_iack_i(ci), .cmd_addr_i(ca),
    .cmd_size_i(cs), .cmd_wdata_i(cd), .rsp_valid_o(rv), .rsp_chain_o(rc),
    .rsp_data_o(rd), .bus_error_n_inject_i(binj), .irq_o(irq));
  hbp_monitor u_hbp_monitor (.clk_i, .rst_i, .half_rate_bus_clock(bus.half_rate_bus_clock), .cs_n(bus.cs_n),
    .ds_n(bus.ds_n), .as_n(bus.as_n), .rw_n(bus.rw_n), .transfer_ack_n_n(bus.transfer_ack_n_n),
    .br_n(bus.br_n), .bus_grant_in_n_n(bus.bus_grant_in_n_n), .bus_grant_out_n_n(bus.bus_grant_out_n_n), .bus_grant_ack_n_n(bus.bus_grant_ack_n_n),
    .bus_error_n_n(bus.bus_error_n_n), .aen_n(bus.aen_n), .address_load_n_n(bus.address_load_n_n), .data_buffer_enable_n_n(bus.data_buffer_enable_n_n),
    .data_buffer_direction_n_n(bus.data_buffer_direction_n_n), .iack_in_n(bus.iack_in_n), .iack_out_n(bus.iack_out_n));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // Sampled mid-cycle so the register updates of the rising edge have settled
  always @(negedge clk_i) begin
    if (rwr) begin
      wcnt++;
      wa = ra;
      wd = rwd;
    end
    if (take)
      tl = lvl;
    if (rrd)
      rdl = {rsz, ra};
    if (pl) begin
      ad_lo = bus.ad;
      a_lo = bus.a;
    end
    if (!bus.address_load_n_n) begin
      ld_ad = bus.ad;
      ld_a = bus.a;
    end
    pl = !bus.address_load_n_n;
  end

  task summarize;
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  task ck(input logic [63:0] g, input logic [63:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : ck

  // Request is held until the rising edge that sees ready, then dropped
  task cmd(input logic w, input logic i, input logic [7:0] a, input logic [1:0] s,
           input logic [15:0] d);
    @(negedge clk_i);
    cw = w;
    ci = i;
    ca = a;
    cs = s;
    cd = d;
    cv = 1;
    #1;
    for (n = 0; n < 40 && !cr; n++) #20;
    @(negedge clk_i);
    cv = 0;
    for (n = 0; n < 60 && !(rv | rc); n++) @(posedge clk_i) #1;
    ck(rv | rc, 1);
    ok = rv;
    chn = rc;
    rsp = rd;
  endtask : cmd

  task dma(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(negedge clk_i);
    dw = w;
    da = a;
    dwd = d;
    dv = 1;
    #1;
    for (n = 0; n < 40 && !dr; n++) #20;
    @(negedge clk_i);
    dv = 0;
    for (n = 0; n < 80 && !(dn | be); n++) @(posedge clk_i) #1;
    ck(dn | be, 1);
  endtask : dma

  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    ck(bus.half_rate_bus_clock_w, 0);
    @(negedge clk_i) rst_i = 0;
    @(posedge clk_i) #1 ck(init, 1);
    @(posedge clk_i) #1 ck(init, 0);
    cmd(1, 0, 8'h40, 2, 16'h1234);
    ck({wa, wd}, {8'h40, 16'h1234});
    cmd(0, 0, 8'h42, 2, 0);
    ck({ok, rsp}, {1'b1, 16'h5a42});
    ck(rdl, {2'h2, 8'h42});
    cmd(0, 0, 8'h43, 1, 0);
    ck(rsp, 16'h4343);
    ck(rdl, {2'h1, 8'h43});
    cmd(1, 0, 8'h41, 1, 16'hab00);
    ck(wd[7:0], 8'hab);
    @(negedge clk_i) strap = 0;
    cmd(1, 0, 8'h40, 2, 16'h5678);
    ck({wa, wd}, {8'h42, 16'h5678});
    cmd(1, 0, 8'h40, 1, 16'hcd00);
    ck({wa, wd[7:0]}, {8'h43, 8'hcd});
    // Unsupported sizes must still be acknowledged, or the host would hang
    for (int s = 0; s < 4; s += 3) begin
      m = wcnt;
      cmd(1, 0, 8'h40, s[1:0], 16'h1111);
      ck({ok, 32'(wcnt - m)}, {1'b1, 32'h0});
    end
    for (int k = 0; k < 3; k++) begin
      @(negedge clk_i) ireq = 3'b001 << k;
      repeat (3) @(negedge clk_i);
      ck(irq, ireq);
    end
    cmd(0, 1, 8'h03, 1, 0);
    ck({ok, rsp, tl}, {1'b1, 16'h0077, 2'h3});
    cmd(0, 1, 8'h02, 1, 0);
    ck({ok, chn}, 2'b01);
    @(negedge clk_i) strap = 1;
    dma(1, 32'h1234_56a0, 16'hbeef);
    ck({dn, ld_ad, ld_a}, {1'b1, 16'h1234, 8'h56});
    ck({ad_lo, a_lo}, {16'h56a0, 8'ha0});
    dma(0, 32'h1234_56a0, 0);
    ck({dn, drd}, {1'b1, 16'hbeef});
    @(negedge clk_i) strap = 0;
    dma(0, 32'h1234_56a0, 0);
    ck(drd, 16'hefbe);
    // Odd byte with the strap low comes from the low lane
    @(negedge clk_i) db = 1;
    dma(0, 32'h1234_56a1, 0);
    ck(drd, 16'h00ef);
    @(negedge clk_i) binj = 1;
    db = 0;
    dma(1, 32'h0000_0010, 16'h0f0f);
    ck({be, dn}, 2'b10);
    repeat (3) @(negedge clk_i);
    ck(irq[0], 1);
    binj = 0;
    bclr = 1;
    @(negedge clk_i) bclr = 0;
    ck(be, 0);
    @(negedge clk_i) test = 1;
    @(negedge clk_i);
    repeat (2) begin
      @(negedge clk_i);
      ck({bus.half_rate_bus_clock_w, bus.bus_grant_out_n_w, bus.iack_out_w}, 3'b111);
    end
    test = 0;
    summarize();
  end
endmodule : host_bus_and_dma_master_port_tb_top
